// ==== design/teic_top.sv ====
// Purpose: Read-only identifier and engine parameter registers on Avalon-MM.
// Assumes: One clock; synchronous inputs; registers at byte offsets 0x0 and 0x4.
// Notes:   A read answers on the next enabled cycle after it is taken; writes are accepted at once and dropped.
// Operation
// - A fixed 32-bit read-only identifier names the engine and its revision.
// - Bits 9-8 report destination queue depth code 2h, a four-entry queue.
// - Bits 5-4 report bus width code 1h, a 64-bit data bus.
// - Bits 2-0 report buffer size code 2h, 128 bytes, on instance zero.
// - Instance one reports buffer size code 3h, 256 bytes; other codes never appear.
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module teic_top #(
  parameter bit ENGINE_INSTANCE_ONE = 1'b0
) (
  // Clock, reset and enable
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        CLK_EN_I,
  // Avalon-MM slave
  input  wire logic [9:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic             AVS_WAITREQUEST_O,
  output logic [31:0]      AVS_READDATA_O
);

  // Reset copy released through two flip-flops
  logic                  rst_sync1_r;
  logic                  rst_sync2_r;
  // Request, bank state and the constant parameter word
  teic_pkg::teic_req_t   req;
  teic_pkg::teic_state_t state_r;
  teic_pkg::teic_state_t state_nxt;
  logic [31:0]           params;
  logic                  read_capture;
  logic                  read_release;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end
    else
    begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end

  assign req = '{address: AVS_ADDRESS_I, read: AVS_READ_I, write: AVS_WRITE_I};

  // True when bit idx lies inside a field of the given position and width.
  function automatic logic in_field(input int idx, input int lsb, input int width);
    return (idx >= lsb) && (idx < lsb + width);
  endfunction : in_field

  // The buffer size code is the only field that differs between instances.
  function automatic logic [2:0] buffer_size_code(input bit instance_one);
    logic [2:0] code;
    if (instance_one)
    begin
      code = teic_pkg::SBS_256_BYTE;
    end
    else
    begin
      code = teic_pkg::SBS_128_BYTE;
    end
    return code;
  endfunction : buffer_size_code

  // One bit of the parameter word; every bit outside the three fields reads zero.
  function automatic logic param_bit(input int idx);
    logic [1:0] depth;
    logic [1:0] bus;
    logic [2:0] size;
    logic       val;
    depth = teic_pkg::DQD_FOUR_ENTRY;
    bus   = teic_pkg::BSC_64BIT;
    size  = buffer_size_code(ENGINE_INSTANCE_ONE);
    val   = 1'b0;
    if (in_field(idx, teic_pkg::DQD_LSB, 2))
    begin
      val = depth[idx - teic_pkg::DQD_LSB];
    end
    else if (in_field(idx, teic_pkg::BSC_LSB, 2))
    begin
      val = bus[idx - teic_pkg::BSC_LSB];
    end
    else if (in_field(idx, teic_pkg::SBS_LSB, 3))
    begin
      val = size[idx - teic_pkg::SBS_LSB];
    end
    return val;
  endfunction : param_bit

  // The parameter word is wired bit by bit from constants, so it holds no state.
  for (genvar b = 0; b < 32; b++)
  begin : g_param_bit
    assign params[b] = param_bit(b);
  end

  function automatic logic addr_is(input logic [9:0] addr, input logic [9:0] ofs);
    return addr == ofs;
  endfunction : addr_is

  function automatic logic [31:0] decode_read(input logic [9:0] addr, input logic [31:0] prm);
    logic [31:0] val;
    val = teic_pkg::UNMAPPED_VAL;
    if (addr_is(addr, teic_pkg::OFS_MODULE_ID))
    begin
      val = teic_pkg::MODULE_ID_VAL;
    end
    else if (addr_is(addr, teic_pkg::OFS_ENGINE_PARAMS))
    begin
      val = prm;
    end
    return val;
  endfunction : decode_read

  // A read is captured on one enabled edge and released on the next enabled edge.
  // The release must wait for the enable, or a frozen valid flag would let the
  // following read finish at once with stale data.
  assign read_capture = req.read && !state_r.rvalid;
  assign read_release = req.read && state_r.rvalid && CLK_EN_I;

  always_comb
  begin
    state_nxt = state_r;
    if (read_capture)
    begin
      state_nxt.readdata = decode_read(req.address, params);
      state_nxt.rvalid   = 1'b1;
    end
    else
    begin
      state_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_sync2_r)
  begin
    if (!rst_sync2_r)
    begin
      state_r <= '0;
    end
    else if (CLK_EN_I)
    begin
      state_r <= state_nxt;
    end
  end

  // Writes never wait and change nothing.
  assign AVS_WAITREQUEST_O = req.read && !read_release;
  assign AVS_READDATA_O    = state_r.readdata;

endmodule : teic_top

`default_nettype wire

// ==== design/teic_pkg.sv ====
// Purpose: Constants and types for the transfer engine identification and configuration bank.
// Assumes: Avalon-MM slave with 32-bit data and byte addressing in words.
// Notes:   The identifier value is arbitrary and names no real part.
package teic_pkg;

  localparam int          ADDR_W            = 10;
  localparam int          DATA_W            = 32;

  // Register byte offsets.
  localparam logic [9:0]  OFS_MODULE_ID     = 10'h000;
  localparam logic [9:0]  OFS_ENGINE_PARAMS = 10'h004;

  // Identifier value, arbitrary.
  localparam logic [31:0] MODULE_ID_VAL     = 32'h0A5C_0101;

  // Field positions of the engine parameter word.
  localparam int          DQD_LSB           = 8;
  localparam int          BSC_LSB           = 4;
  localparam int          SBS_LSB           = 0;

  // Field codes.
  localparam logic [1:0]  DQD_FOUR_ENTRY    = 2'h2;
  localparam logic [1:0]  BSC_64BIT         = 2'h1;
  localparam logic [2:0]  SBS_128_BYTE      = 3'h2;
  localparam logic [2:0]  SBS_256_BYTE      = 3'h3;

  // Answer for unmapped addresses.
  localparam logic [31:0] UNMAPPED_VAL      = 32'h0000_0000;

  // Bus request carried as one struct.
  typedef struct packed {
    logic [9:0]  address;
    logic        read;
    logic        write;
  } teic_req_t;

  // Whole state of the bank.
  typedef struct packed {
    logic [31:0] readdata;
    logic        rvalid;
  } teic_state_t;

endpackage : teic_pkg

// ==== tb/teic_props.sv ====
// Purpose: Bank checks.
// Assumes: A read ends where waitrequest is low.
// Notes: Bound from the bench.
`timescale 1ns/100ps
`default_nettype none
module teic_props #(
  parameter bit ENGINE_INSTANCE_ONE = 1'b0
) (
  input wire logic        SYS_CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        CLK_EN_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic [9:0]  AVS_ADDRESS_I,
  input wire logic [31:0] AVS_READDATA_O
);
  wire logic [31:0] d = AVS_READDATA_O;
  wire logic        e = AVS_READ_I && !AVS_WAITREQUEST_O;
  wire logic        p = e && AVS_ADDRESS_I == teic_pkg::OFS_ENGINE_PARAMS;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_read_captured;
    AVS_READ_I && CLK_EN_I && !e;
  endsequence
  sequence s_read_released;
    e || !CLK_EN_I;
  endsequence
  a_read_done: assert property (s_read_captured |=> s_read_released) else $error("wait");
  a_id_value: assert property (e && AVS_ADDRESS_I == teic_pkg::OFS_MODULE_ID |-> d == teic_pkg::MODULE_ID_VAL)
    else $error("id");
  a_write_nowait: assert property (AVS_WRITE_I && !AVS_READ_I |-> !AVS_WAITREQUEST_O) else $error("write wait");
  a_stall_hold: assert property (!CLK_EN_I |-> AVS_WAITREQUEST_O == AVS_READ_I) else $error("stall");
  a_data_frozen: assert property (!CLK_EN_I |=> $stable(AVS_READDATA_O)) else $error("frozen");
  a_depth_code: assert property (p |-> d[9:8] == 2'h2) else $error("depth");
  a_bus_code: assert property (p |-> d[5:4] == 2'h1) else $error("bus");
  a_size_code: assert property (p |-> d[2:0] == 3'h2 + ENGINE_INSTANCE_ONE) else $error("size");
  a_rsvd_zero: assert property (p |-> (d & 32'hFFFF_FCC8) == 32'h0) else $error("rsvd");
endmodule : teic_props
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Bench for the bank.
// Assumes: Instances zero and one, driven side by side.
// Notes: Writes carry random data.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                ce = 1'b1;
  logic                wt;
  logic                wt1;
  logic [31:0]         wd = 32'h112E;
  logic [31:0]         cs = 32'h112E;
  logic [31:0]         rd;
  logic [31:0]         rd1;
  logic [31:0]         q[$];
  logic [31:0]         q1[$];
  teic_pkg::teic_req_t r = '0;
  int                  errors = 0;
  int                  compares = 0;
  int                  n;
  teic_top i_teic_top (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(ce),
    .AVS_ADDRESS_I(r.address), .AVS_READ_I(r.read), .AVS_WRITE_I(r.write),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(wd[3:0]), .AVS_WAITREQUEST_O(wt), .AVS_READDATA_O(rd));
  teic_top #(.ENGINE_INSTANCE_ONE(1'b1)) i_teic_top_one (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
    .CLK_EN_I(ce), .AVS_ADDRESS_I(r.address), .AVS_READ_I(r.read), .AVS_WRITE_I(r.write),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(wd[3:0]), .AVS_WAITREQUEST_O(wt1),
    .AVS_READDATA_O(rd1));
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  // The clock enable drops about one cycle in four, so reads stall now and then.
  always @(posedge clk)
  begin
    cs <= xs(cs);
    ce <= cs[0] || cs[1];
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    compares++;
    if (seen !== expected)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check
  task automatic results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] e,
                     input logic [31:0] e1);
    @(posedge clk);
    r  <= '{a, !w, w};
    wd <= xs(wd);
    if (!w)
    begin
      q.push_back(e);
      q1.push_back(e1);
    end
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (!wt) break;
    end
    r <= '0;
    errors += int'(n == 50);
    if (n == 50) results();
  endtask : acc
  always @(posedge clk)
  begin
    if (r.read && !wt)
    begin
      check(rd, q.pop_front());
      check(rd1, q1.pop_front());
      check({31'h0, wt1}, 32'h0);
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, 10'(i * 4), '0, '0);
      acc(1'b0, teic_pkg::OFS_MODULE_ID, teic_pkg::MODULE_ID_VAL, teic_pkg::MODULE_ID_VAL);
      acc(1'b0, teic_pkg::OFS_ENGINE_PARAMS, 32'h0000_0212, 32'h0000_0213);
      acc(1'b0, {wd[9:4], 4'h8}, '0, '0);
    end
    results();
  end
endmodule : testbench
bind teic_top teic_props #(.ENGINE_INSTANCE_ONE(ENGINE_INSTANCE_ONE)) i_teic_props (
  .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .CLK_EN_I(CLK_EN_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READDATA_O(AVS_READDATA_O));
`default_nettype wire
